// ### hw/spd_pkg.sv
package spd_pkg;
    // Geometry
    localparam int unsigned REG_W    = 64;
    localparam int unsigned NUM_REGS = 8;
    localparam int unsigned IDX_W    = 3;
    localparam int unsigned HALF_W   = 32;
    localparam int unsigned MEM_BYTES = 8;

    // Operation codes from the decoder
    typedef enum logic [3:0] {
        SPD_OP_NOP     = 4'h0,
        SPD_OP_MOV64   = 4'h1, // Reg to reg, whole block
        SPD_OP_LOAD64  = 4'h2,
        SPD_OP_LOAD32  = 4'h3, // Also integer reg to SIMD
        SPD_OP_STORE64 = 4'h4,
        SPD_OP_STORE32 = 4'h5, // Also SIMD to integer reg
        SPD_OP_ADD     = 4'h6, // Wraparound add
        SPD_OP_ADDS    = 4'h7, // Saturating add at byte width only, signedness by isSigned
        SPD_OP_SUB     = 4'h8,
        SPD_OP_AND     = 4'h9,
        SPD_OP_OR      = 4'ha,
        SPD_OP_XOR     = 4'hb,
        SPD_OP_CMPEQ   = 4'hc,
        SPD_OP_CMPGT   = 4'hd,
        SPD_OP_UNPKLO  = 4'he, // Low-half interleave, 32-bit access
        SPD_OP_EMPTY   = 4'hf  // empty_simd_state
    } spd_op_t;

    typedef enum logic [1:0] {
        SPD_EL_BYTE  = 2'h0,
        SPD_EL_WORD  = 2'h1,
        SPD_EL_DWORD = 2'h2,
        SPD_EL_QWORD = 2'h3
    } spd_elem_t;

    // Tag word value meaning "all entries empty"
    localparam logic [7:0] TAG_EMPTY = 8'hff;
    localparam logic [7:0] TAG_NONE  = 8'h00;
endpackage

// ### hw/spd_rf_if.sv
`timescale 1ns/1ps
// Port bundle between datapath and shared register storage
interface spd_rf_if;
    import spd_pkg::*;
    logic [IDX_W-1:0] rdIdxA;
    logic [IDX_W-1:0] rdIdxB;
    logic [REG_W-1:0] rdDataA;
    logic [REG_W-1:0] rdDataB;
    logic             wrEn;
    logic [IDX_W-1:0] wrIdx;
    logic [REG_W-1:0] wrData;
    modport store (input rdIdxA, rdIdxB, wrEn, wrIdx, wrData,
                   output rdDataA, rdDataB);
    modport user  (output rdIdxA, rdIdxB, wrEn, wrIdx, wrData,
                   input rdDataA, rdDataB);
endinterface

// ### hw/spd_regfile.sv
`timescale 1ns/1ps
// Eight 64-bit entries, one storage for both SIMD and FP views
module spd_regfile
    import spd_pkg::*;
(
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst_n,
    // Datapath side
    spd_rf_if.store    rf
);
    logic [REG_W-1:0] mem [NUM_REGS];

    // Single array, so a write through either view shows in both
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                mem[i] <= '0;
            end
        end else if (rf.wrEn) begin
            mem[rf.wrIdx] <= rf.wrData;
        end
    end

    // Registered read ports
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rf.rdDataA <= '0;
            rf.rdDataB <= '0;
        end else begin
            rf.rdDataA <= mem[rf.rdIdxA];
            rf.rdDataB <= mem[rf.rdIdxB];
        end
    end
endmodule

// ### hw/spd_datapath.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Eight 64-bit registers, selected by instruction field
// - Registers are data only, never addresses
// - Storage shared with floating-point stack entries
// - Byte n sits at bits 8n..8n+7
// - Four words, lowest at bits 0..15
// - Two doublewords, low at bits 0..31
// - Whole 64-bit transfers, elementwise parallel arithmetic
// - Signed and unsigned element interpretation supported
// - Signed byte add writes eight byte results
// - Stores are little-endian, low element first
// - 64-bit access for moves, arithmetic, logic
// - 32-bit access for 32-bit transfers, unpacks
// - Decoder recognises all instruction groups plus empty
// - Element width comes from instruction, not register
// - No new mode or extra visible state
module spd_datapath
    import spd_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Issue from decoder
    input  wire logic                      issueValid,
    input  wire spd_op_t                   issueOp,
    input  wire spd_elem_t                 issueElem,
    input  wire logic                      isSigned,
    input  wire logic [IDX_W-1:0]          dstIdx,
    input  wire logic [IDX_W-1:0]          srcIdx,
    input  wire logic                      srcIsMem,
    // Load data from load/store unit or integer register
    input  wire logic [REG_W-1:0]          loadData,
    // FP view of the shared storage
    input  wire logic                      fpWrEn,
    input  wire logic [IDX_W-1:0]          fpWrIdx,
    input  wire logic [REG_W-1:0]          fpWrData,
    input  wire logic [IDX_W-1:0]          fpRdIdx,
    // Results
    output logic                           doneValid,
    output logic [REG_W-1:0]               storeData,
    output logic [MEM_BYTES-1:0]           storeByteEn,
    output logic [MEM_BYTES*8-1:0]         storeBytes,
    output logic                           storeValid,
    output logic [REG_W-1:0]               fpRdData,
    output logic [7:0]                     fpTagWord
);
    spd_rf_if rf ();

    spd_regfile u_rf (
        .clk   (clk),
        .rst_n (rst_n),
        .rf    (rf)
    );

    typedef enum logic [1:0] {
        SPD_ST_IDLE  = 2'b00,
        SPD_ST_EXEC  = 2'b01
    } spd_state_t;

    spd_state_t       state_r;
    spd_op_t          op_r;
    spd_elem_t        elem_r;
    logic             signed_r;
    logic [IDX_W-1:0] dst_r;
    logic             srcMem_r;
    logic [REG_W-1:0] load_r;
    logic             fpPend_r;
    logic [7:0]       tag_r;
    logic [REG_W-1:0] result;
    logic             wrRes;

    // Lane add with carry cut at every element edge; sub via invert
    function automatic logic [REG_W-1:0] lane_add(
        input logic [REG_W-1:0] a,
        input logic [REG_W-1:0] b,
        input spd_elem_t el,
        input logic sat,
        input logic sgn,
        input logic sub);
        logic [REG_W-1:0] r;
        logic [8:0]       s;
        logic [7:0]       bb;
        logic             cin;
        logic             ovf;
        r = '0;
        cin = sub;
        for (int i = 0; i < MEM_BYTES; i++) begin
            bb = sub ? ~b[8*i +: 8] : b[8*i +: 8];
            // Carry restarts at each lane edge
            if (el == SPD_EL_BYTE || (el == SPD_EL_WORD && i % 2 == 0) ||
                (el == SPD_EL_DWORD && i % 4 == 0) || i == 0) begin
                cin = sub;
            end
            s = {1'b0, a[8*i +: 8]} + {1'b0, bb} + {8'h00, cin};
            r[8*i +: 8] = s[7:0];
            cin = s[8];
            // Saturation for bytes only, at lane top
            if (sat && el == SPD_EL_BYTE) begin
                ovf = sgn ? ((a[8*i+7] == bb[7]) && (s[7] != a[8*i+7]))
                          : (s[8] != sub);
                if (ovf) begin
                    if (sgn) begin
                        r[8*i +: 8] = a[8*i+7] ? 8'h80 : 8'h7f;
                    end else begin
                        r[8*i +: 8] = sub ? 8'h00 : 8'hff;
                    end
                end
            end
        end
        return r;
    endfunction

    // Lanewise compare, mask of ones on true
    function automatic logic [REG_W-1:0] lane_cmp(
        input logic [REG_W-1:0] a,
        input logic [REG_W-1:0] b,
        input spd_elem_t el,
        input logic gt);
        logic [REG_W-1:0] r;
        r = '0;
        unique case (el)
            SPD_EL_BYTE: for (int i = 0; i < 8; i++)
                r[8*i +: 8] = (gt ? ($signed(a[8*i +: 8]) >
                    $signed(b[8*i +: 8])) : (a[8*i +: 8] == b[8*i +: 8]))
                    ? 8'hff : 8'h00;
            SPD_EL_WORD: for (int i = 0; i < 4; i++)
                r[16*i +: 16] = (gt ? ($signed(a[16*i +: 16]) >
                    $signed(b[16*i +: 16])) : (a[16*i +: 16] ==
                    b[16*i +: 16])) ? 16'hffff : 16'h0000;
            SPD_EL_DWORD: for (int i = 0; i < 2; i++)
                r[32*i +: 32] = (gt ? ($signed(a[32*i +: 32]) >
                    $signed(b[32*i +: 32])) : (a[32*i +: 32] ==
                    b[32*i +: 32])) ? 32'hffffffff : 32'h00000000;
            SPD_EL_QWORD: r = (a == b) ? '1 : '0;
        endcase
        return r;
    endfunction

    // Read ports: SIMD dst/src, or FP view when no issue pending
    always_comb begin
        rf.rdIdxA = issueValid ? dstIdx : fpRdIdx;
        rf.rdIdxB = srcIdx;
    end

    // Issue capture; operands come out of storage one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= SPD_ST_IDLE;
            op_r     <= SPD_OP_NOP;
            elem_r   <= SPD_EL_BYTE;
            signed_r <= 1'b0;
            dst_r    <= '0;
            srcMem_r <= 1'b0;
            load_r   <= '0;
            fpPend_r <= 1'b0;
        end else begin
            state_r  <= issueValid ? SPD_ST_EXEC : SPD_ST_IDLE;
            op_r     <= issueOp;
            elem_r   <= issueElem;
            signed_r <= isSigned;
            dst_r    <= dstIdx;
            srcMem_r <= srcIsMem;
            load_r   <= loadData;
            fpPend_r <= !issueValid;
        end
    end

    // Element datapath; source may be memory data, never an address
    always_comb begin
        logic [REG_W-1:0] a;
        logic [REG_W-1:0] b;
        a = rf.rdDataA;
        b = srcMem_r ? load_r : rf.rdDataB;
        result = a;
        wrRes = 1'b0;
        if (state_r == SPD_ST_EXEC) begin
            wrRes = 1'b1;
            unique case (op_r)
                SPD_OP_MOV64, SPD_OP_LOAD64: result = b;
                SPD_OP_LOAD32: result = {{HALF_W{1'b0}},
                    b[HALF_W-1:0]};
                SPD_OP_ADD:  result = lane_add(a, b, elem_r, 1'b0,
                    signed_r, 1'b0);
                SPD_OP_ADDS: result = lane_add(a, b, elem_r, 1'b1,
                    signed_r, 1'b0);
                SPD_OP_SUB:  result = lane_add(a, b, elem_r, 1'b0,
                    signed_r, 1'b1);
                SPD_OP_AND:  result = a & b;
                SPD_OP_OR:   result = a | b;
                SPD_OP_XOR:  result = a ^ b;
                SPD_OP_CMPEQ: result = lane_cmp(a, b, elem_r, 1'b0);
                SPD_OP_CMPGT: result = lane_cmp(a, b, elem_r, 1'b1);
                SPD_OP_UNPKLO: result = {b[31:24], a[31:24], b[23:16],
                    a[23:16], b[15:8], a[15:8], b[7:0], a[7:0]};
                SPD_OP_NOP, SPD_OP_STORE64, SPD_OP_STORE32,
                SPD_OP_EMPTY: wrRes = 1'b0;
            endcase
        end
    end

    // Single write port: SIMD result has priority over FP write
    always_comb begin
        rf.wrEn   = wrRes || fpWrEn;
        rf.wrIdx  = wrRes ? dst_r : fpWrIdx;
        rf.wrData = wrRes ? result : fpWrData;
    end

    // Store path, little-endian byte image, low element first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            storeValid  <= 1'b0;
            storeData   <= '0;
            storeBytes  <= '0;
            storeByteEn <= '0;
        end else begin
            storeValid <= (state_r == SPD_ST_EXEC) &&
                (op_r == SPD_OP_STORE64 || op_r == SPD_OP_STORE32);
            storeData  <= rf.rdDataA;
            for (int i = 0; i < MEM_BYTES; i++) begin
                storeBytes[8*i +: 8] <= rf.rdDataA[8*i +: 8];
            end
            storeByteEn <= (op_r == SPD_OP_STORE32) ? 8'h0f : 8'hff;
        end
    end

    // Completion and FP-view read-out
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            doneValid <= 1'b0;
            fpRdData  <= '0;
        end else begin
            doneValid <= (state_r == SPD_ST_EXEC);
            if (fpPend_r) begin
                fpRdData <= rf.rdDataA;
            end
        end
    end

    // Only the shared tag word; no private mode bit exists
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fpTagWord <= TAG_EMPTY;
        end else if (state_r == SPD_ST_EXEC) begin
            fpTagWord <= (op_r == SPD_OP_EMPTY) ? TAG_EMPTY
                                                : TAG_NONE;
        end
    end

    // Byte add: lanes 1 and 4 must not see the carry of the lane below
    a_lane_isolate: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state_r == SPD_ST_EXEC && op_r == SPD_OP_ADD &&
         elem_r == SPD_EL_BYTE && !srcMem_r)
        |-> rf.wrData[15:8] == 8'(rf.rdDataA[15:8] + rf.rdDataB[15:8])
        && rf.wrData[39:32] == 8'(rf.rdDataA[39:32] + rf.rdDataB[39:32]))
        else $error("byte lane carry check");

    a_empty_tags: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state_r == SPD_ST_EXEC && op_r == SPD_OP_EMPTY)
        |=> fpTagWord == TAG_EMPTY)
        else $error("empty did not mark all tags");

    a_store_pulse: assert property (
        @(posedge clk) disable iff (!rst_n)
        (issueValid && issueOp == SPD_OP_STORE64) |-> ##2 storeValid
        ##0 storeByteEn == 8'hff)
        else $error("store64 not full width");

    a_store_half: assert property (
        @(posedge clk) disable iff (!rst_n)
        (issueValid && issueOp == SPD_OP_STORE32) |-> ##2
        storeByteEn == 8'h0f)
        else $error("store32 byte enable wrong");

    a_done_lat: assert property (
        @(posedge clk) disable iff (!rst_n)
        issueValid |-> ##2 doneValid)
        else $error("completion latency wrong");

    a_store_le: assert property (
        @(posedge clk) disable iff (!rst_n)
        storeValid |-> storeBytes[7:0] == storeData[7:0])
        else $error("store byte order wrong");

    a_mov_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state_r == SPD_ST_EXEC && op_r == SPD_OP_MOV64)
        |-> rf.wrEn && rf.wrIdx == dst_r)
        else $error("move did not write dst");

    a_no_mem_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state_r == SPD_ST_EXEC && op_r == SPD_OP_STORE64)
        |-> !wrRes)
        else $error("store wrote register");
endmodule

// ### tb/spd_lsu_model.sv
`timescale 1ns/1ps
// Memory behind the load/store path: 16 bytes, byte addressed
module spd_lsu_model
    import spd_pkg::*;
(
    // Clock
    input  wire logic                 clk,
    // Bench preload, address and load request
    input  wire logic                 preWr,
    input  wire logic [REG_W-1:0]     preData,
    input  wire logic [3:0]           addr,
    input  wire logic                 loadReq,
    // Datapath side
    input  wire logic                 storeValid,
    input  wire logic [MEM_BYTES-1:0] storeByteEn,
    input  wire logic [REG_W-1:0]     storeBytes,
    output logic      [REG_W-1:0]     loadData,
    output logic      [REG_W-1:0]     memView
);
    logic [7:0] mem [16];

    // Lowest address holds the least significant byte
    always_comb begin
        for (int i = 0; i < MEM_BYTES; i++) begin
            memView[8*i +: 8] = mem[addr + 4'(i)];
        end
    end

    // Scrambled outside a load, so stale data never passes for fresh
    assign loadData = loadReq ? memView : ~memView;

    // Byte lanes written under their enables on a store; a preload writes all eight
    always_ff @(posedge clk) begin
        for (int i = 0; i < MEM_BYTES; i++) begin
            if (preWr) begin
                mem[addr + 4'(i)] <= preData[8*i +: 8];
            end else if (storeValid && storeByteEn[i]) begin
                mem[addr + 4'(i)] <= storeBytes[8*i +: 8];
            end
        end
    end
endmodule

// ### tb/simd_packed_datapath_tb_top.sv
`timescale 1ns/1ps
module simd_packed_datapath_tb_top
    import spd_pkg::*;
;
    logic             clk, rst_n, issueValid, isSigned, srcIsMem;
    logic             fpWrEn, doneValid, storeValid, preWr;
    spd_op_t          op;
    spd_elem_t        el;
    logic [IDX_W-1:0] dstIdx, srcIdx, fpWrIdx, fpRdIdx;
    logic [REG_W-1:0] fpWrData, loadData, storeData, storeBytes;
    logic [REG_W-1:0] fpRdData, memView, preData, v;
    logic [7:0]       storeByteEn, fpTagWord;
    logic [3:0]       addr;
    logic [REG_W-1:0] shadow [NUM_REGS];
    int               n_errors, comparisons;
    spd_op_t          ops [8] = '{SPD_OP_ADD, SPD_OP_ADDS, SPD_OP_SUB,
        SPD_OP_AND, SPD_OP_OR, SPD_OP_XOR, SPD_OP_CMPEQ, SPD_OP_CMPGT};

    spd_datapath dut (.clk(clk), .rst_n(rst_n), .issueValid(issueValid),
        .issueOp(op), .issueElem(el), .isSigned(isSigned),
        .dstIdx(dstIdx), .srcIdx(srcIdx), .srcIsMem(srcIsMem),
        .loadData(loadData), .fpWrEn(fpWrEn), .fpWrIdx(fpWrIdx),
        .fpWrData(fpWrData), .fpRdIdx(fpRdIdx), .doneValid(doneValid),
        .storeData(storeData), .storeByteEn(storeByteEn),
        .storeBytes(storeBytes), .storeValid(storeValid),
        .fpRdData(fpRdData), .fpTagWord(fpTagWord));
    spd_lsu_model lsu (.clk(clk), .preWr(preWr), .preData(preData),
        .addr(addr), .loadReq(issueValid & srcIsMem),
        .storeValid(storeValid), .storeByteEn(storeByteEn),
        .storeBytes(storeBytes), .loadData(loadData), .memView(memView));

    task automatic final_report;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(logic [REG_W-1:0] got, logic [REG_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Reference result, lane by lane so no carry crosses a lane
    function automatic logic [REG_W-1:0] calc(spd_op_t o, spd_elem_t e,
            logic s, logic [REG_W-1:0] a, logic [REG_W-1:0] b);
        int w;
        longint x, y, z, m;
        logic [REG_W-1:0] r;
        w = 8 << e;
        m = (longint'(1) << w) - 1;
        r = '0;
        if (o == SPD_OP_MOV64) return b;
        if (o == SPD_OP_AND) return a & b;
        if (o == SPD_OP_OR) return a | b;
        if (o == SPD_OP_XOR) return a ^ b;
        // Low-half interleave: destination bytes on even positions
        if (o == SPD_OP_UNPKLO) begin
            for (int i = 0; i < 4; i++) begin
                r[16*i +: 8] = a[8*i +: 8];
                r[16*i+8 +: 8] = b[8*i +: 8];
            end
            return r;
        end
        for (int i = 0; i < REG_W; i += w) begin
            x = longint'(a >> i) & m;
            y = longint'(b >> i) & m;
            // Compare-greater is always signed
            if ((s || o == SPD_OP_CMPGT) && x[w-1]) x = x | ~m;
            if ((s || o == SPD_OP_CMPGT) && y[w-1]) y = y | ~m;
            z = (o == SPD_OP_SUB) ? x - y : x + y;
            if (o == SPD_OP_CMPEQ) z = (x == y) ? -1 : 0;
            if (o == SPD_OP_CMPGT) z = (x > y) ? -1 : 0;
            if (o == SPD_OP_ADDS && z > (s ? 127 : 255)) z = s ? 127 : 255;
            if (o == SPD_OP_ADDS && z < (s ? -128 : 0)) z = s ? -128 : 0;
            r = r | (64'(z & m) << i);
        end
        return r;
    endfunction

    // One instruction, then a bounded wait for its completion pulse
    task automatic issue(spd_op_t o, spd_elem_t e, logic s,
            logic [IDX_W-1:0] d, logic [IDX_W-1:0] sr, logic mem);
        int k;
        @(posedge clk);
        issueValid <= 1'b1;
        op <= o;
        el <= e;
        isSigned <= s;
        dstIdx <= d;
        srcIdx <= sr;
        srcIsMem <= mem;
        @(posedge clk);
        issueValid <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (doneValid !== 1'b1 && storeValid !== 1'b1 && k < 4);
        if (doneValid !== 1'b1 && storeValid !== 1'b1) begin
            n_errors++;
            $display("ERROR at %0t got %h expected %h", $time,
                     doneValid, 1'b1);
            final_report();
        end
        check(64'(k), 64'h1);
    endtask

    task automatic store_chk(logic [IDX_W-1:0] d);
        issue(SPD_OP_STORE64, SPD_EL_QWORD, 1'b0, d, d, 1'b0);
        check(storeData, shadow[d]);
        check(storeBytes, shadow[d]);
        check({56'h0, storeByteEn}, 64'hff);
        @(posedge clk);
        #1;
        check(memView, shadow[d]);
    endtask

    task automatic preload(logic [3:0] a, logic [REG_W-1:0] val);
        @(posedge clk);
        preWr <= 1'b1;
        preData <= val;
        addr <= a;
        @(posedge clk);
        preWr <= 1'b0;
    endtask

    task automatic load_chk(logic [IDX_W-1:0] d, logic [REG_W-1:0] val,
            logic half);
        preload({1'b0, d}, val);
        issue(half ? SPD_OP_LOAD32 : SPD_OP_LOAD64, SPD_EL_QWORD, 1'b0,
              d, d, 1'b1);
        shadow[d] = half ? {32'h0, val[31:0]} : val;
        store_chk(d);
    endtask

    task automatic op_chk(spd_op_t o, spd_elem_t e, logic s,
            logic [IDX_W-1:0] d, logic [IDX_W-1:0] sr);
        issue(o, e, s, d, sr, 1'b0);
        shadow[d] = calc(o, e, s, shadow[d], shadow[sr]);
        store_chk(d);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        spd_op_t o;
        {rst_n, issueValid, isSigned, srcIsMem, fpWrEn, preWr} = '0;
        {dstIdx, srcIdx, fpWrIdx, fpRdIdx, addr} = '0;
        {fpWrData, preData} = '0;
        op = SPD_OP_NOP;
        el = SPD_EL_BYTE;
        n_errors = 0;
        comparisons = 0;
        v = 64'($urandom(32'h6ff2fe3e));
        foreach (shadow[i]) shadow[i] = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check({56'h0, fpTagWord}, {56'h0, TAG_EMPTY});
        for (int r = 0; r < NUM_REGS; r++) store_chk(3'(r));
        for (int r = 0; r < NUM_REGS; r++) begin
            load_chk(3'(r), {$urandom, $urandom}, 1'b0);
        end
        for (int r = 0; r < NUM_REGS; r++) begin
            @(posedge clk);
            fpRdIdx <= 3'(r);
            repeat (3) @(posedge clk);
            #1;
            check(fpRdData, shadow[r]);
        end
        check({56'h0, fpTagWord}, {56'h0, TAG_NONE});
        @(posedge clk);
        fpWrEn <= 1'b1;
        fpWrIdx <= 3'h6;
        fpWrData <= v;
        @(posedge clk);
        fpWrEn <= 1'b0;
        shadow[6] = v;
        store_chk(3'h6);
        // Lane corners: carries and borrows at byte, word and dword width, saturation at byte width only
        load_chk(3'h1, 64'h7f80_ff01_7fff_8000, 1'b0);
        load_chk(3'h2, 64'h0180_0101_0001_ffff, 1'b0);
        for (int e = 0; e < 3; e++) begin
            for (int k = 0; k < 16; k++) begin
                if (k[2:0] == 3'h1 && e != 0) continue;
                op_chk(SPD_OP_MOV64, SPD_EL_QWORD, 1'b0, 3'h3, 3'h1);
                op_chk(ops[k[2:0]], spd_elem_t'(e), k[3], 3'h3, 3'h2);
            end
        end
        op_chk(SPD_OP_UNPKLO, SPD_EL_BYTE, 1'b0, 3'h3, 3'h2);
        op_chk(SPD_OP_UNPKLO, SPD_EL_DWORD, 1'b0, 3'h4, 3'h1);
        // Random operations; saturation is byte wide only
        for (int n = 0; n < 60; n++) begin
            o = ops[$urandom_range(7)];
            if ($urandom_range(3) == 0) begin
                load_chk(3'($urandom), {$urandom, $urandom}, 1'b0);
            end
            op_chk(o, (o == SPD_OP_ADDS) ? SPD_EL_BYTE :
                   spd_elem_t'($urandom_range(2)), 1'($urandom),
                   3'($urandom), 3'($urandom));
        end
        // Half-width load zero-extends; half store touches four bytes
        v = {$urandom, $urandom};
        load_chk(3'h5, v, 1'b1);
        preload(4'h5, ~v);
        issue(SPD_OP_STORE32, SPD_EL_DWORD, 1'b0, 3'h5, 3'h5, 1'b0);
        check({56'h0, storeByteEn}, 64'h0f);
        check({32'h0, storeBytes[31:0]}, {32'h0, v[31:0]});
        @(posedge clk);
        #1;
        check(memView, {~v[63:32], v[31:0]});
        issue(SPD_OP_EMPTY, SPD_EL_QWORD, 1'b0, 3'h0, 3'h0, 1'b0);
        @(posedge clk);
        #1;
        check({56'h0, fpTagWord}, {56'h0, TAG_EMPTY});
        // Reset in mid-run clears the storage again
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check({56'h0, fpTagWord}, {56'h0, TAG_EMPTY});
        foreach (shadow[i]) shadow[i] = '0;
        store_chk(3'h3);
        final_report();
    end
endmodule
